/* File: rtl/dcs_bkpt_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// breakpoint match address storage with registered compare
module dcs_bkpt_reg #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  input  wire logic             i_we,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [WIDTH-1:0] i_cmp_addr,
  input  wire logic             i_cmp_valid,
  output logic      [WIDTH-1:0] o_rdata,
  output logic                  o_match
);

  logic [WIDTH-1:0] match_addr_q;
  logic             match_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      match_addr_q <= WIDTH'(dcs_pkg::RESET_BKPT);
    end else if (i_ce && i_we) begin
      match_addr_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      match_q <= 1'b0;
    end else if (i_ce) begin
      match_q <= i_cmp_valid && (i_cmp_addr == match_addr_q);
    end
  end

  assign o_rdata = match_addr_q;
  assign o_match = match_q;

endmodule
`default_nettype wire

/* File: rtl/dcs_ctrl_status.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] 8-bit control/status register, controls plus status
// [R2] 16-bit breakpoint match address register
// [R3] reachable only by serial debug commands
// [R4] halt-permit write ignored while halted
// [R5] four status flags are read-only
// [R6] clock select always writable, resets to 0
// [R7] halt-permit holds until reset; 0 refuses halt; code rewrites it on any unblocked control write while not halted
// [R8] halted flag shows debug-mode halt
// [R9] breakpoint disabled ignores type and address
// [R10] force mode: match halts at instruction boundary
// [R11] tag mode: tagged opcode halts at queue end
// [R12] low-power flag: wait/stop or halted from it
// [R13] in wait/stop only halt request operates; code also lets status reads and clock select writes through
// [R14] host confirms halted flag after forcing halt
// [R15] low-power failure flag on conflicting access
// [R16] host recovers low-power failure by halt, retry
// [R17] slow-access failure flag always zero
// [R18] status read code e4 returns register
// [R19] control write code c4 updates writable bits
// [R20] breakpoint enable resets to 0
module dcs_ctrl_status #(
  parameter int ADDR_W = dcs_pkg::ADDR_WIDTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  input  var  dcs_pkg::dcs_cmd_t i_cmd,
  input  var  dcs_pkg::dcs_cpu_t i_cpu,
  input  wire logic             i_tag_at_queue_end,
  output logic                  o_rsp_valid,
  output logic [15:0]           o_rsp_data,
  output logic                  o_cmd_refused,
  output logic                  o_halt_request,
  output logic                  o_force_bkpt,
  output logic                  o_tag_opcode,
  output logic                  o_tag_halt,
  output logic                  o_comm_clock_select
);

  // writable controls
  logic halt_permit_q;
  logic breakpoint_enable_q;
  logic force_or_tag_select_q;
  logic comm_clock_select_q;
  // status
  logic low_power_failure_flag_q;
  logic low_power_flag;
  logic halted_flag;
  logic slow_access_failure_flag;

  logic [15:0] rsp_data_q;
  logic        rsp_valid_q;
  logic        refused_q;
  logic        halt_req_q;

  logic        is_status_rd;
  logic        is_ctrl_wr;
  logic        is_bkpt_rd;
  logic        is_bkpt_wr;
  logic        is_bkgd;
  logic        blocked;
  logic        bkpt_match;
  logic [15:0] bkpt_rdata;
  logic [7:0]  status_byte;

  // only the serial command path reaches these registers; no cpu bus port exists
  assign is_status_rd = i_cmd.valid && (i_cmd.code == dcs_pkg::CMD_READ_STATUS);   // [R3] [R18]
  assign is_ctrl_wr   = i_cmd.valid && (i_cmd.code == dcs_pkg::CMD_WRITE_CONTROL); // [R3] [R19]
  assign is_bkpt_rd   = i_cmd.valid && (i_cmd.code == dcs_pkg::CMD_READ_BKPT);
  assign is_bkpt_wr   = i_cmd.valid && (i_cmd.code == dcs_pkg::CMD_WRITE_BKPT);
  assign is_bkgd      = i_cmd.valid && (i_cmd.code == dcs_pkg::CMD_BACKGROUND);

  // status reads stay allowed so the host can see the low-power flag
  assign blocked = i_cpu.low_power && !i_cpu.halted && !is_bkgd && !is_status_rd; // [R13]

  assign halted_flag              = i_cpu.halted;                                   // [R8]
  assign low_power_flag           = i_cpu.low_power || (i_cpu.halted && i_cpu.lp_from_bkgd); // [R12]
  assign slow_access_failure_flag = 1'b0;                                           // [R17]

  assign status_byte = {halt_permit_q, halted_flag, breakpoint_enable_q,            // [R1]
                        force_or_tag_select_q, comm_clock_select_q, low_power_flag,
                        low_power_failure_flag_q, slow_access_failure_flag};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      halt_permit_q <= dcs_pkg::RESET_CONTROL[dcs_pkg::BIT_HALT_PERMIT];              // [R7]
    end else if (i_ce && is_ctrl_wr && !blocked && !i_cpu.halted) begin             // [R4]
      halt_permit_q <= i_cmd.data[dcs_pkg::BIT_HALT_PERMIT];                         // [R7]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      breakpoint_enable_q   <= dcs_pkg::RESET_CONTROL[dcs_pkg::BIT_BKPT_ENABLE];     // [R20]
      force_or_tag_select_q <= dcs_pkg::RESET_CONTROL[dcs_pkg::BIT_FORCE_TAG];
    end else if (i_ce && is_ctrl_wr && !blocked) begin                              // [R19]
      breakpoint_enable_q   <= i_cmd.data[dcs_pkg::BIT_BKPT_ENABLE];
      force_or_tag_select_q <= i_cmd.data[dcs_pkg::BIT_FORCE_TAG];
    end
  end

  // clock select is writable in every state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      comm_clock_select_q <= dcs_pkg::RESET_CONTROL[dcs_pkg::BIT_CLOCK_SELECT];      // [R6]
    end else if (i_ce && is_ctrl_wr) begin
      comm_clock_select_q <= i_cmd.data[dcs_pkg::BIT_CLOCK_SELECT];                 // [R6]
    end
  end

  // set wins over clear; a new halt starts a fresh recovery so halt clears it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      low_power_failure_flag_q <= dcs_pkg::RESET_CONTROL[dcs_pkg::BIT_LP_FAILURE];
    end else if (i_ce) begin
      if (i_cpu.mem_cmd_failed_lp) begin
        low_power_failure_flag_q <= 1'b1;                                            // [R15]
      end else if (halt_req_q) begin
        low_power_failure_flag_q <= 1'b0;
      end
    end
  end
  // control write never touches halted, low-power or failure flags              // [R5]

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      halt_req_q <= 1'b0;
    end else if (i_ce) begin
      halt_req_q <= is_bkgd && halt_permit_q && !i_cpu.halted;                      // [R7] [R13]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
      refused_q   <= 1'b0;
    end else if (i_ce) begin
      rsp_valid_q <= (is_status_rd || is_bkpt_rd) && !blocked;
      refused_q   <= (i_cmd.valid && blocked) || (is_bkgd && !halt_permit_q);       // [R13] [R7]
      if (is_status_rd) begin
        rsp_data_q <= {8'h00, status_byte};                                          // [R18]
      end else if (is_bkpt_rd && !blocked) begin
        rsp_data_q <= bkpt_rdata;                                                    // [R2]
      end
    end
  end

  dcs_bkpt_reg #(
    .WIDTH (ADDR_W)
  ) u_bkpt (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_ce        (i_ce),
    .i_we        (is_bkpt_wr && !blocked),                                          // [R2]
    .i_wdata     (i_cmd.data[ADDR_W-1:0]),
    .i_cmp_addr  (i_cpu.addr[ADDR_W-1:0]),
    .i_cmp_valid (i_cpu.addr_valid && !i_cpu.halted),
    .o_rdata     (bkpt_rdata),
    .o_match     (bkpt_match)
  );

  // breakpoints need halt permission as well, or the cpu could not stop
  assign o_force_bkpt   = breakpoint_enable_q && halt_permit_q && force_or_tag_select_q && bkpt_match;  // [R9] [R10]
  assign o_tag_opcode   = breakpoint_enable_q && halt_permit_q && !force_or_tag_select_q && bkpt_match; // [R9] [R11]
  assign o_tag_halt     = breakpoint_enable_q && halt_permit_q && !force_or_tag_select_q
                          && i_tag_at_queue_end;                                                         // [R11]
  assign o_halt_request = halt_req_q;
  assign o_rsp_valid    = rsp_valid_q;
  assign o_rsp_data     = rsp_data_q;
  assign o_cmd_refused  = refused_q;
  assign o_comm_clock_select = comm_clock_select_q;

endmodule
`default_nettype wire

/* File: rtl/dcs_pkg.sv */
package dcs_pkg;

  // serial command codes
  localparam logic [7:0] CMD_READ_STATUS   = 8'he4;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
  localparam logic [7:0] CMD_READ_BKPT     = 8'he2;
  localparam logic [7:0] CMD_WRITE_BKPT    = 8'hc2;
  localparam logic [7:0] CMD_BACKGROUND    = 8'h90;

  // control/status field positions
  localparam int BIT_HALT_PERMIT   = 7;
  localparam int BIT_HALTED        = 6;
  localparam int BIT_BKPT_ENABLE   = 5;
  localparam int BIT_FORCE_TAG     = 4;
  localparam int BIT_CLOCK_SELECT  = 3;
  localparam int BIT_LOW_POWER     = 2;
  localparam int BIT_LP_FAILURE    = 1;
  localparam int BIT_SLOW_FAILURE  = 0;

  // reset values
  localparam logic [7:0]  RESET_CONTROL = 8'h00;
  localparam logic [15:0] RESET_BKPT    = 16'h0000;

  localparam int REG_WIDTH  = 8;
  localparam int ADDR_WIDTH = 16;

  // decoded command from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [15:0] data;
  } dcs_cmd_t;

  // cpu-side observation
  typedef struct packed {
    logic        halted;
    logic        low_power;
    logic        lp_from_bkgd;
    logic        mem_cmd_failed_lp;
    logic        addr_valid;
    logic [15:0] addr;
  } dcs_cpu_t;

endpackage

/* File: verification/dcs_ctrl_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_status_bench;
  logic              i_clk = 1'b0;
  logic              i_reset = 1'b1;
  logic              tq = 1'b0;
  dcs_pkg::dcs_cmd_t cmd;
  dcs_pkg::dcs_cpu_t cpu = '0;
  logic              rv, ref_q, hr, fb, tg, th, cs;
  logic [15:0]       rd;
  int                num_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  always #2 i_clk = ~i_clk;
  dcs_host_model host (.i_clk(i_clk), .o_cmd(cmd));
  dcs_ctrl_status DUT (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_cmd(cmd), .i_cpu(cpu),
    .i_tag_at_queue_end(tq), .o_rsp_valid(rv), .o_rsp_data(rd), .o_cmd_refused(ref_q),
    .o_halt_request(hr), .o_force_bkpt(fb), .o_tag_opcode(tg), .o_tag_halt(th), .o_comm_clock_select(cs));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic status(input logic [7:0] exp);
    host.send(dcs_pkg::CMD_READ_STATUS, 16'h0000);
    check("status", rd, {8'h00, exp});
  endtask
  task automatic ctl(input logic [7:0] v);
    host.send(dcs_pkg::CMD_WRITE_CONTROL, {8'h00, v});
  endtask
  always @(posedge i_clk) if (++cycles > 2000) begin
    num_errors++;
    results;
  end
  initial begin
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
    status(8'h00);
    check("clock select", cs, 16'h0000);
    ctl(8'hff);
    status(8'hb8);
    check("clock select", cs, 16'h0001);
    host.send(dcs_pkg::CMD_WRITE_BKPT, 16'h1234);
    host.send(dcs_pkg::CMD_READ_BKPT, 16'h0000);
    check("bkpt", rd, 16'h1234);
    cpu.halted = 1'b1;
    ctl(8'h30);
    status(8'hf0);
    cpu = '{addr_valid: 1'b1, addr: 16'h1234, default: 1'b0};
    @(negedge i_clk) check("force", {fb, tg}, 16'h0002);
    cpu.addr = 16'h1235;
    @(negedge i_clk) check("force off", {fb, tg}, 16'h0000);
    cpu.addr = 16'h1234;
    ctl(8'ha0);
    tq = 1'b1;
    @(negedge i_clk) check("tag", {fb, tg, th}, 16'h0003);
    tq = 1'b0;
    ctl(8'h90);
    @(negedge i_clk) check("disabled", {fb, tg}, 16'h0000);
    cpu.addr_valid = 1'b0;
    host.send(dcs_pkg::CMD_BACKGROUND, 16'h0000);
    check("halt", {hr, ref_q}, 16'h0002);
    ctl(8'h00);
    host.send(dcs_pkg::CMD_BACKGROUND, 16'h0000);
    check("no halt", {hr, ref_q}, 16'h0001);
    ctl(8'h80);
    cpu.low_power = 1'b1;
    ctl(8'h08);
    check("refused", {ref_q, cs}, 16'h0003);
    status(8'h8c);
    cpu.mem_cmd_failed_lp = 1'b1;
    @(negedge i_clk) cpu.mem_cmd_failed_lp = 1'b0;
    status(8'h8e);
    host.send(dcs_pkg::CMD_BACKGROUND, 16'h0000);
    check("halt from wait", hr, 16'h0001);
    cpu = '{halted: 1'b1, lp_from_bkgd: 1'b1, default: 1'b0};
    // confirm the halt before anything else
    status(8'hcc);
    results;
  end
endmodule
`default_nettype wire

/* File: verification/dcs_ctrl_status_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_status_chk (
  input wire logic              i_clk,
  input wire logic              i_reset,
  input wire logic              i_ce,
  input var  dcs_pkg::dcs_cmd_t i_cmd,
  input var  dcs_pkg::dcs_cpu_t i_cpu,
  input wire logic              o_rsp_valid,
  input wire logic [15:0]       o_rsp_data,
  input wire logic              o_cmd_refused,
  input wire logic              o_halt_request,
  input wire logic              o_comm_clock_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic rd;
  logic wr;
  logic lp;
  assign rd = i_ce && i_cmd.valid && i_cmd.code == dcs_pkg::CMD_READ_STATUS;
  assign wr = i_ce && i_cmd.valid && i_cmd.code == dcs_pkg::CMD_WRITE_CONTROL;
  assign lp = i_cpu.low_power && !i_cpu.halted;
  status_answer_a: assert property (rd |=> o_rsp_valid && o_rsp_data[15:8] == 8'h00)
    else $error("status read not answered");
  slow_fail_a: assert property (rd |=> !o_rsp_data[0])
    else $error("slow access failure reported");
  halted_shown_a: assert property (rd && $stable(i_cpu.halted) |=> o_rsp_data[6] == $past(i_cpu.halted))
    else $error("halted flag wrong");
  low_power_a: assert property (rd && lp && $past(lp) |=> o_rsp_data[2])
    else $error("low power flag missing");
  refuse_lp_a: assert property (wr && lp |=> o_cmd_refused)
    else $error("control write not refused in low power");
  clock_sel_a: assert property (wr && !lp |=> o_comm_clock_select == $past(i_cmd.data[3]))
    else $error("clock select not written");
  clock_hold_a: assert property (!$stable(o_comm_clock_select) |-> $past(wr) || $past(i_reset))
    else $error("clock select changed without write");
  halt_cause_a: assert property (o_halt_request |-> $past(i_ce && i_cmd.valid && i_cmd.code == 8'h90))
    else $error("halt request without command");
endmodule
bind dcs_ctrl_status dcs_ctrl_status_chk u_chk (.i_clk, .i_reset, .i_ce, .i_cmd, .i_cpu, .o_rsp_valid,
  .o_rsp_data, .o_cmd_refused, .o_halt_request, .o_comm_clock_select);
`default_nettype wire

/* File: verification/dcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  input wire logic              i_clk,
  output var dcs_pkg::dcs_cmd_t o_cmd
);
  initial o_cmd = '0;
  // released fields show inverted garbage so stale data never looks valid
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    @(negedge i_clk);
    o_cmd = '{valid: 1'b1, code: code, data: data};
    @(negedge i_clk);
    o_cmd = '{valid: 1'b0, code: ~code, data: ~data};
  endtask
endmodule
`default_nettype wire
